// File: rtl/gsb_top.sv
// gsb_top: sixteen-pin status and drive bank with its register port
//
// Functional notes
// - an input pin's status bit reads one while the pin sits at its asserted level.
// - writing one to an output pin's status bit drives that pin to its asserted level.
// - polarity of pins 0 to 3 comes from bits 1, 3, 5, 7 of the first pin config register.
// - polarity of pins 4 to 7 comes from bits 1, 3, 5, 7 of the second pin config register.
// - polarity of pins 8 to 11 comes from bits 1, 3, 5, 7 of the third pin config register.
// - polarity of pins 12 to 15 comes from bits 1, 3, 5, 7 of the fourth pin config register.
// - a status bit takes writes only while its pin is an output, otherwise writes are dropped.
// - pins 8 to 15 sit in bits 0 to 7 of the register at 25h, which resets to 00h.
// - pins 0 to 7 sit in bits 0 to 7 of a second status register, pin 7 in the top bit.
// - the register for pins 0 to 7 sits at 24h and resets to 00h.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module gsb_top (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// register port
	input  wire gsb_pkg::gsb_bus_req_t bus_req,
	output logic [gsb_pkg::DATA_W-1:0] rd_data,
	// pins
	input  wire logic [gsb_pkg::PIN_N-1:0] pin_in,
	output logic      [gsb_pkg::PIN_N-1:0] pin_out,
	output logic      [gsb_pkg::PIN_N-1:0] pin_oe
);
	import gsb_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [GRP_N-1:0][DATA_W-1:0] cfg;
		logic [PIN_N-1:0]             stat;
		logic [DATA_W-1:0]            rd_data;
		gsb_pin_drv_t                 drv;
		logic [SYNC_FILL-1:0]         warm;
	} gsb_st_t;

	gsb_st_t          st;
	gsb_st_t          next_st;
	logic [PIN_N-1:0] pin_val;
	logic [PIN_N-1:0] dir_vec;
	logic [PIN_N-1:0] pol_vec;
	logic [PIN_N-1:0] asserted;

	// ------------------------------------------------------------
	// input synchroniser
	// ------------------------------------------------------------
	gsb_pin_sync #(
		.W(PIN_N)
	) u_sync (
		.clk    (clk),
		.sys_rst(sys_rst),
		.pin_raw(pin_in),
		.pin_val(pin_val)
	);

	// ------------------------------------------------------------
	// config decode
	// ------------------------------------------------------------
	always_comb begin
		dir_vec = {gsb_dir_of(st.cfg[3]), gsb_dir_of(st.cfg[2]),
			gsb_dir_of(st.cfg[1]), gsb_dir_of(st.cfg[0])};
		pol_vec = {gsb_pol_of(st.cfg[3]), gsb_pol_of(st.cfg[2]),
			gsb_pol_of(st.cfg[1]), gsb_pol_of(st.cfg[0])};
		asserted = ~(pin_val ^ pol_vec);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rd_data = RD_IDLE;

		// a freshly reset filter reads all-low, which active-low pins would
		// report as asserted; input bits keep their cleared value until it refills
		next_st.warm = {st.warm[SYNC_FILL-2:0], 1'b1};
		for (int i = 0; i < PIN_N; i++) begin
			if (!dir_vec[i] && st.warm[SYNC_FILL-1]) begin
				next_st.stat[i] = asserted[i];
			end
		end

		// writes land only on output bits; input bits keep the pin value
		if (bus_req.wr_en) begin
			unique case (bus_req.addr)
				CFG0_OFF: next_st.cfg[0] = bus_req.wdata;
				CFG1_OFF: next_st.cfg[1] = bus_req.wdata;
				CFG2_OFF: next_st.cfg[2] = bus_req.wdata;
				CFG3_OFF: next_st.cfg[3] = bus_req.wdata;
				STAT_LO_OFF: begin
					next_st.stat[7:0] = (next_st.stat[7:0] & ~dir_vec[7:0])
						| (bus_req.wdata & dir_vec[7:0]);
				end
				STAT_HI_OFF: begin
					next_st.stat[15:8] = (next_st.stat[15:8] & ~dir_vec[15:8])
						| (bus_req.wdata & dir_vec[15:8]);
				end
				default: ;
			endcase
		end

		// read data is valid in the following cycle only; holes read zero
		if (bus_req.rd_en) begin
			unique case (bus_req.addr)
				CFG0_OFF:    next_st.rd_data = st.cfg[0];
				CFG1_OFF:    next_st.rd_data = st.cfg[1];
				CFG2_OFF:    next_st.rd_data = st.cfg[2];
				CFG3_OFF:    next_st.rd_data = st.cfg[3];
				STAT_LO_OFF: next_st.rd_data = st.stat[7:0];
				STAT_HI_OFF: next_st.rd_data = st.stat[15:8];
				default:     next_st.rd_data = RD_IDLE;
			endcase
		end

		// pin drive lags the status bit by one cycle, keeping outputs on flops
		next_st.drv.oe = dir_vec;
		next_st.drv.level = ~(st.stat ^ pol_vec);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.stat <= {STAT_HI_RST, STAT_LO_RST};
			st.cfg <= {GRP_N{CFG_RST}};
			st.rd_data <= RD_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;
	assign pin_out = st.drv.level;
	assign pin_oe  = st.drv.oe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_input_status: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && $past(st.warm[SYNC_FILL-1]))
		|-> ((st.stat ^ $past(asserted)) & ~$past(dir_vec)) == '0)
		else $error("input status bit does not follow asserted pin");

	a_warm_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && !$past(st.warm[SYNC_FILL-1]))
		|-> ((st.stat ^ $past(st.stat)) & ~$past(dir_vec)) == '0)
		else $error("input status bit moved before the synchroniser refilled");

	a_output_level: assert property (@(posedge clk) disable iff (sys_rst)
		((pin_out ^ $past(st.stat) ^ $past(pol_vec)) | ~pin_oe) == '1)
		else $error("output pin level disagrees with status and polarity");

	a_oe_follow: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) |-> pin_oe == $past(dir_vec))
		else $error("pin drive enable does not follow direction");

	a_pol_group_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.wr_en && bus_req.addr == CFG0_OFF) |-> ##2
		((pin_out[3:0] ^ $past(st.stat[3:0]) ^ gsb_pol_of($past(bus_req.wdata, 2))) | ~pin_oe[3:0]) == 4'hF)
		else $error("pins 0-3 polarity not taken from first config");

	a_pol_group_one: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.wr_en && bus_req.addr == CFG1_OFF) |-> ##2
		((pin_out[7:4] ^ $past(st.stat[7:4]) ^ gsb_pol_of($past(bus_req.wdata, 2))) | ~pin_oe[7:4]) == 4'hF)
		else $error("pins 4-7 polarity not taken from second config");

	a_pol_group_two: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.wr_en && bus_req.addr == CFG2_OFF) |-> ##2
		((pin_out[11:8] ^ $past(st.stat[11:8]) ^ gsb_pol_of($past(bus_req.wdata, 2))) | ~pin_oe[11:8]) == 4'hF)
		else $error("pins 8-11 polarity not taken from third config");

	a_pol_group_three: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.wr_en && bus_req.addr == CFG3_OFF) |-> ##2
		((pin_out[15:12] ^ $past(st.stat[15:12]) ^ gsb_pol_of($past(bus_req.wdata, 2))) | ~pin_oe[15:12]) == 4'hF)
		else $error("pins 12-15 polarity not taken from fourth config");

	a_write_accept: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.wr_en && bus_req.addr == STAT_LO_OFF) |=>
		((st.stat[7:0] ^ $past(bus_req.wdata)) & $past(dir_vec[7:0])) == 8'h00)
		else $error("write to output bit of low status not taken");

	a_write_high: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.wr_en && bus_req.addr == STAT_HI_OFF) |=>
		((st.stat[15:8] ^ $past(bus_req.wdata)) & $past(dir_vec[15:8])) == 8'h00)
		else $error("write to output bit of high status not taken");

	a_output_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && !($past(bus_req.wr_en)
			&& ($past(bus_req.addr) == STAT_LO_OFF || $past(bus_req.addr) == STAT_HI_OFF)))
		|-> ((st.stat ^ $past(st.stat)) & $past(dir_vec)) == '0)
		else $error("output status bit changed without a write");

	a_read_high: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.rd_en && bus_req.addr == STAT_HI_OFF) |=> rd_data == $past(st.stat[15:8]))
		else $error("read of 25h does not return pins 8-15");

	a_read_low: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.rd_en && bus_req.addr == STAT_LO_OFF) |=> rd_data == $past(st.stat[7:0]))
		else $error("read of 24h does not return pins 0-7");

	a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(bus_req.rd_en) |-> rd_data == RD_IDLE)
		else $error("read data present without a read");

	a_reset_clear: assert property (@(posedge clk)
		$past(sys_rst) |-> (st.stat == '0 && pin_oe == '0))
		else $error("status or drive not cleared by reset");

endmodule
`default_nettype wire

// File: rtl/gsb_pkg.sv
// gsb_pkg: shared constants and carrier types of the pin status bank
package gsb_pkg;

	// ------------------------------------------------------------
	// bus widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PIN_N  = 16;
	localparam int GRP_N  = 4;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CFG0_OFF    = 8'h08;
	localparam logic [ADDR_W-1:0] CFG1_OFF    = 8'h09;
	localparam logic [ADDR_W-1:0] CFG2_OFF    = 8'h0A;
	localparam logic [ADDR_W-1:0] CFG3_OFF    = 8'h0B;
	localparam logic [ADDR_W-1:0] STAT_LO_OFF = 8'h24;
	localparam logic [ADDR_W-1:0] STAT_HI_OFF = 8'h25;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] STAT_LO_RST = 8'h00;
	localparam logic [DATA_W-1:0] STAT_HI_RST = 8'h00;
	localparam logic [DATA_W-1:0] CFG_RST     = 8'h00;
	localparam logic [DATA_W-1:0] RD_IDLE     = 8'h00;

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	// cycles after reset before the filtered pin value can be trusted
	localparam int SYNC_FILL = 4;

	// ------------------------------------------------------------
	// config field positions: each byte covers four pins
	// ------------------------------------------------------------
	localparam int DIR_POS0 = 0;
	localparam int POL_POS0 = 1;
	localparam int DIR_POS1 = 2;
	localparam int POL_POS1 = 3;
	localparam int DIR_POS2 = 4;
	localparam int POL_POS2 = 5;
	localparam int DIR_POS3 = 6;
	localparam int POL_POS3 = 7;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic              wr_en;
		logic              rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} gsb_bus_req_t;

	typedef struct packed {
		logic [PIN_N-1:0] level;
		logic [PIN_N-1:0] oe;
	} gsb_pin_drv_t;

	// direction bits, one per pin, 1 = output
	function automatic logic [3:0] gsb_dir_of(input logic [DATA_W-1:0] b);
		return {b[DIR_POS3], b[DIR_POS2], b[DIR_POS1], b[DIR_POS0]};
	endfunction

	// polarity bits, one per pin, 1 = active high
	function automatic logic [3:0] gsb_pol_of(input logic [DATA_W-1:0] b);
		return {b[POL_POS3], b[POL_POS2], b[POL_POS1], b[POL_POS0]};
	endfunction

endpackage

// File: rtl/gsb_pin_sync.sv
// gsb_pin_sync: three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module gsb_pin_sync #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// pins and result
	input  wire logic [W-1:0] pin_raw,
	output logic      [W-1:0] pin_val
);
	import gsb_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} gsb_sync_st_t;

	gsb_sync_st_t st;
	gsb_sync_st_t next_st;

	// s1 is read only by s2; a change counts once s2 and s3 agree
	always_comb begin
		next_st = st;
		next_st.s1 = pin_raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.val[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_val = st.val;

	a_sync_agree: assert property (@(posedge clk) disable iff (sys_rst)
		(!$past(sys_rst) && st.val != $past(st.val))
		|-> ((((st.val ^ $past(st.val)) & ($past(st.s2) ^ $past(st.s3))) == '0)
			&& (((st.val ^ $past(st.s3)) & (st.val ^ $past(st.val))) == '0)))
		else $error("filtered pin changed without stage agreement");

endmodule
`default_nettype wire

// File: sim/gsb_top_tb.sv
// gsb_top_tb: self-checking bench for the pin status bank against a bench model
`timescale 1ns/1ns
`default_nettype none

module gsb_top_tb;
	import gsb_pkg::*;

	// ------------------------------------------------------------
	// signals and model state
	// ------------------------------------------------------------
	logic              clk         = 1'b0;
	logic              sys_rst     = 1'b1;
	gsb_bus_req_t      bus_req     = '0;
	logic [PIN_N-1:0]  pin_in      = 16'hFFFF;
	logic [DATA_W-1:0] rd_data;
	logic [PIN_N-1:0]  pin_out;
	logic [PIN_N-1:0]  pin_oe;
	int                errors      = 0;
	int                checks_done = 0;
	logic [DATA_W-1:0] m_cfg [GRP_N];
	logic [PIN_N-1:0]  m_stat, m_dir, m_pol, d;
	logic [DATA_W-1:0] v;

	always #5 clk = ~clk;

	gsb_top i_gsb_top (
		.clk     (clk),
		.sys_rst (sys_rst),
		.bus_req (bus_req),
		.rd_data (rd_data),
		.pin_in  (pin_in),
		.pin_out (pin_out),
		.pin_oe  (pin_oe)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk);
		bus_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: wd};
		@(posedge clk);
		bus_req.wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] rv);
		@(posedge clk);
		bus_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus_req.rd_en <= 1'b0;
		#1 rv = rd_data;
	endtask

	// pin k of a group: direction at bit 2k, polarity at bit 2k+1
	task automatic model_cfg();
		for (int i = 0; i < PIN_N; i++) begin
			m_dir[i] = m_cfg[i/4][2*(i%4)];
			m_pol[i] = m_cfg[i/4][2*(i%4)+1];
		end
	endtask

	// input bits follow the pin: set while pin level equals its polarity
	task automatic settle();
		for (int i = 0; i < PIN_N; i++) begin
			if (!m_dir[i]) m_stat[i] = (pin_in[i] == m_pol[i]);
		end
	endtask

	// pins held at FFFFh so active-low defaults read deasserted
	task automatic reset_check();
		pin_in <= 16'hFFFF;
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rd(STAT_LO_OFF, v); chk(16'(v), 16'(STAT_LO_RST));
		rd(STAT_HI_OFF, v); chk(16'(v), 16'(STAT_HI_RST));
		chk(pin_oe, 16'h0000);
		chk(pin_out, 16'hFFFF);
		rd(CFG0_OFF, v); chk(16'(v), 16'(CFG_RST));
		m_stat = '0;
		for (int g = 0; g < GRP_N; g++) m_cfg[g] = CFG_RST;
		model_cfg();
	endtask

	task automatic stop_test();
		$display("TB: checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(89));
		reset_check();
		// unmapped place: write dropped, read idle, data stands one cycle
		wr(8'h30, 8'hFF);
		rd(8'h30, v); chk(16'(v), 16'(RD_IDLE));
		@(posedge clk);
		#1 chk(16'(rd_data), 16'(RD_IDLE));
		for (int n = 0; n < 40; n++) begin
			for (int g = 0; g < GRP_N; g++) begin
				m_cfg[g] = 8'($urandom);
				wr(8'(CFG0_OFF + g), m_cfg[g]);
			end
			model_cfg();
			pin_in <= 16'($urandom);
			repeat (8) @(posedge clk);
			settle();
			d = 16'($urandom);
			wr(STAT_LO_OFF, d[7:0]);
			wr(STAT_HI_OFF, d[15:8]);
			m_stat = (m_stat & ~m_dir) | (d & m_dir);
			repeat (2) @(posedge clk);
			#1 chk(pin_oe, m_dir);
			chk(pin_out & m_dir, ~(m_stat ^ m_pol) & m_dir);
			rd(STAT_LO_OFF, v); chk(16'(v), 16'(m_stat[7:0]));
			rd(STAT_HI_OFF, v); chk(16'(v), 16'(m_stat[15:8]));
			for (int g = 0; g < GRP_N; g++) begin
				rd(8'(CFG0_OFF + g), v); chk(16'(v), 16'(m_cfg[g]));
			end
			// read data stands one cycle only, then returns to idle
			@(posedge clk);
			#1 chk(16'(rd_data), 16'(RD_IDLE));
		end
		// pin 0 input active high: a fresh edge is not visible before the synchroniser
		wr(CFG0_OFF, 8'h02);
		pin_in <= 16'h0000;
		repeat (8) @(posedge clk);
		rd(STAT_LO_OFF, v); chk(16'(v[0]), 16'h0000);
		pin_in <= 16'h0001;
		rd(STAT_LO_OFF, v); chk(16'(v[0]), 16'h0000);
		repeat (8) @(posedge clk);
		rd(STAT_LO_OFF, v); chk(16'(v[0]), 16'h0001);
		reset_check();
		stop_test();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		stop_test();
	end

endmodule

`default_nettype wire
